// File: inc/ehs_pkg.sv
`default_nettype none
package ehs_pkg;
   // Serial word sizes
   localparam int unsigned BYTE_W      = 8;
   localparam int unsigned WORD3_BITS  = 9;
   localparam logic [3:0]  CNT_ZERO    = 4'h0;
   localparam logic [3:0]  CNT_BYTE    = 4'h8;
   localparam logic [3:0]  CNT_WORD3   = 4'h9;
   // Strap levels
   localparam logic        STRAP_4LINE = 1'b0;
   localparam logic        STRAP_3LINE = 1'b1;
   // Data/command flag encoding
   localparam logic        DC_CMD      = 1'b0;
   localparam logic        DC_DATA     = 1'b1;
endpackage : ehs_pkg
`default_nettype wire

// File: inc/ehs_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
// Synchronised serial pin levels handed to the shifter
interface ehs_pin_if;
   logic sclk;
   logic sdi;
   logic dc;
   logic cs_n;
   modport src (output sclk, output sdi, output dc, output cs_n);
   modport dst (input sclk, input sdi, input dc, input cs_n);
endinterface : ehs_pin_if
`default_nettype wire

// File: rtl/ehs_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ehs_sync (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // Raw pins
   input  wire logic sclk_i,
   input  wire logic sdi_i,
   input  wire logic dc_i,
   input  wire logic cs_n_i,
   // Synchronised side
   ehs_pin_if.src    pins
);
   logic [3:0] s1_q;
   logic [3:0] s2_q;

   // Two-stage synchroniser; first stage read only by second
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 4'h1;
         s2_q <= 4'h1;
      end else begin
         s1_q <= {sclk_i, sdi_i, dc_i, cs_n_i};
         s2_q <= s1_q;
      end
   end

   assign pins.sclk = s2_q[3];
   assign pins.sdi  = s2_q[2];
   assign pins.dc   = s2_q[1];
   assign pins.cs_n = s2_q[0];
endmodule : ehs_sync
`default_nettype wire

// File: rtl/ehs_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module ehs_ctrl (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // Host pins
   input  wire logic       module_clear_n_i,
   input  wire logic       bus_mode_strap_i,
   input  wire logic       cs_n_i,
   input  wire logic       sclk_i,
   input  wire logic       sdi_i,
   input  wire logic       dc_i,
   output logic            busy_o,
   // Core side
   input  wire logic       work_wave_i,
   input  wire logic       work_temp_i,
   output logic [7:0]      rx_byte_o,
   output logic            rx_is_data_o,
   output logic            rx_valid_o,
   output logic            core_clear_o
);
   ehs_pin_if pins ();
   logic       clr_s1_q;
   logic       clr_s2_q;
   logic       strap_s1_q;
   logic       strap_s2_q;
   logic       three_line_q;
   logic       sclk_prev_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic       dc_flag_q;
   logic       rise;
   logic       in_reset;
   logic       last_bit;

   // Pin synchroniser
   ehs_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .sclk_i    (sclk_i),
      .sdi_i     (sdi_i),
      .dc_i      (dc_i),
      .cs_n_i    (cs_n_i),
      .pins      (pins)
   );

   // Reset pin and strap synchronisers
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clr_s1_q   <= 1'b0;
         clr_s2_q   <= 1'b0;
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end else begin
         clr_s1_q   <= module_clear_n_i;
         clr_s2_q   <= clr_s1_q;
         strap_s1_q <= bus_mode_strap_i;
         strap_s2_q <= strap_s1_q;
      end
   end

   // Reset level, qualified clock edge and final-bit decode
   assign in_reset = !clr_s2_q;
   assign rise     = pins.sclk && !sclk_prev_q && !pins.cs_n;
   assign last_bit = three_line_q ? (cnt_q == ehs_pkg::CNT_WORD3 - 4'h1)
                                  : (cnt_q == ehs_pkg::CNT_BYTE - 4'h1);

   // Core held clear while reset pin low
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_clear_o <= 1'b1;
      end else begin
         core_clear_o <= in_reset;
      end
   end

   // Mode latched from strap while in reset
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         three_line_q <= 1'b0;
      end else if (in_reset) begin
         three_line_q <= (strap_s2_q == ehs_pkg::STRAP_3LINE);
      end
   end

   // Serial clock edge history
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= pins.sclk;
      end
   end

   // Bit shifter and unit assembly
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q        <= ehs_pkg::CNT_ZERO;
         shift_q      <= 8'h00;
         dc_flag_q    <= ehs_pkg::DC_CMD;
         rx_byte_o    <= 8'h00;
         rx_is_data_o <= 1'b0;
         rx_valid_o   <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (in_reset || pins.cs_n) begin
            cnt_q <= ehs_pkg::CNT_ZERO;
         end else if (rise) begin
            if (three_line_q && cnt_q == ehs_pkg::CNT_ZERO) begin
               dc_flag_q <= pins.sdi;
               cnt_q     <= cnt_q + 4'h1;
            end else begin
               shift_q <= {shift_q[6:0], pins.sdi};
               if (last_bit) begin
                  cnt_q        <= ehs_pkg::CNT_ZERO;
                  rx_byte_o    <= {shift_q[6:0], pins.sdi};
                  rx_valid_o   <= 1'b1;
                  // Flag bit in 3-line, pin level in 4-line
                  rx_is_data_o <= three_line_q ? dc_flag_q
                                               : (pins.dc == ehs_pkg::DC_DATA);
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
         end
      end
   end

   // Busy while any internal work runs, held low while the reset pin is low
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= !in_reset && (work_wave_i || work_temp_i);
      end
   end

   // Assertions on busy
   a_busy_follows_work: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!in_reset && work_wave_i) |=> busy_o)
      else $error("busy low during work");
   a_busy_temp_work: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!in_reset && work_temp_i) |=> busy_o)
      else $error("busy low during sensor work");
   a_busy_drops_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!work_wave_i && !work_temp_i) |=> !busy_o)
      else $error("busy high with no work");

   // Assertions on the reset pin and mode latch
   a_clear_tracks_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      in_reset |=> core_clear_o)
      else $error("core not cleared");
   a_clear_releases: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !in_reset |=> !core_clear_o)
      else $error("core clear stuck high");
   a_busy_idle_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      in_reset |=> !busy_o)
      else $error("busy during reset");
   a_clear_drops_unit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      in_reset |=> (cnt_q == ehs_pkg::CNT_ZERO))
      else $error("bit count kept in reset");
   a_clear_no_rx: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      in_reset |=> !rx_valid_o)
      else $error("unit delivered in reset");
   a_mode_follows_strap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      in_reset |=> (three_line_q == $past(strap_s2_q)))
      else $error("mode not taken from strap");
   a_mode_held: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !in_reset |=> $stable(three_line_q))
      else $error("mode changed outside reset");

   // Assertions on chip select gating
   a_no_rx_unselected: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ($past(pins.cs_n) && pins.cs_n) |-> !rx_valid_o)
      else $error("byte taken while deselected");
   a_rx_needs_select: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rx_valid_o |-> !$past(pins.cs_n))
      else $error("unit finished without select");
   a_deselect_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pins.cs_n |=> (cnt_q == ehs_pkg::CNT_ZERO))
      else $error("partial unit kept after deselect");

   // Assertions on unit assembly
   a_count_bound: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cnt_q < ehs_pkg::CNT_WORD3)
      else $error("bit counter overrun");
   a_rise_one_shot: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rise |=> !rise)
      else $error("serial edge seen twice");
   a_valid_one_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rx_valid_o |=> !rx_valid_o)
      else $error("valid longer than one cycle");
   a_byte_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !rx_valid_o |-> $stable(rx_byte_o))
      else $error("byte changed without valid");
   a_flag_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !rx_valid_o |-> $stable(rx_is_data_o))
      else $error("flag changed without valid");
   a_four_line_dc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rise && !three_line_q && cnt_q == 4'h7 && !in_reset) |=>
      (rx_valid_o && rx_is_data_o == $past(pins.dc)))
      else $error("4-line flag mismatch");
   a_byte_msb_first: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rise && !three_line_q && cnt_q == 4'h7 && !in_reset) |=>
      rx_byte_o == {$past(shift_q[6:0]), $past(pins.sdi)})
      else $error("byte order wrong");
   a_flag_capture: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rise && three_line_q && cnt_q == ehs_pkg::CNT_ZERO && !in_reset) |=>
      (dc_flag_q == $past(pins.sdi)))
      else $error("3-line flag bit not taken");
   a_three_line_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rise && three_line_q && cnt_q == 4'h8 && !in_reset) |=>
      (rx_valid_o && rx_is_data_o == $past(dc_flag_q)))
      else $error("3-line flag mismatch");
   a_three_line_byte: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rise && three_line_q && cnt_q == 4'h8 && !in_reset) |=>
      rx_byte_o == {$past(shift_q[6:0]), $past(pins.sdi)})
      else $error("3-line byte order wrong");
endmodule : ehs_ctrl
`default_nettype wire

// File: test/ehs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ehs_host_model (
   // Clock and busy
   input  wire logic ref_clk_i,
   input  wire logic busy_i,
   // Serial pins
   output var logic  sclk_o,
   output var logic  sdi_o,
   output var logic  dc_o,
   output var logic  cs_n_o
);
   // Idle link
   initial begin
      sclk_o = 1'b0;
      sdi_o  = 1'b0;
      dc_o   = 1'b0;
      cs_n_o = 1'b1;
   end
   // Sends n bits MSB first, then releases the link
   task automatic send(input logic [8:0] w, input int n, input logic dc);
      @(negedge ref_clk_i);
      while (busy_i !== 1'b0) @(negedge ref_clk_i);
      dc_o   = dc;
      cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o = w[i];
         repeat (4) @(negedge ref_clk_i);
         sclk_o = 1'b1;
         repeat (4) @(negedge ref_clk_i);
         sclk_o = 1'b0;
      end
      repeat (4) @(negedge ref_clk_i);
      cs_n_o = 1'b1;
      sdi_o  = ~sdi_o; // Released line shows no stale bit
      repeat (4) @(negedge ref_clk_i);
   endtask : send
   // Toggles clock and data n times with chip select left high
   task automatic stray(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk_i);
         sdi_o  = ~sdi_o;
         repeat (4) @(negedge ref_clk_i);
         sclk_o = 1'b1;
         repeat (4) @(negedge ref_clk_i);
         sclk_o = 1'b0;
      end
      repeat (4) @(negedge ref_clk_i);
   endtask : stray
endmodule : ehs_host_model
`default_nettype wire

// File: test/test_epaper_host_serial_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_epaper_host_serial_ctrl;
   logic       ref_clk_i, rst_i, module_clear_n_i, bus_mode_strap_i;
   logic       work_wave_i, work_temp_i, sclk, sdi, dc, cs_n;
   logic       busy_o, rx_is_data_o, rx_valid_o, core_clear_o;
   logic [7:0] rx_byte_o;
   logic [8:0] w;
   logic [8:0] exp_q[$];
   int         bad_count, checked, cycles, seed;
   // Clock
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   ehs_ctrl i_ehs_ctrl (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .module_clear_n_i(module_clear_n_i), .bus_mode_strap_i(bus_mode_strap_i),
      .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .dc_i(dc), .busy_o(busy_o),
      .work_wave_i(work_wave_i), .work_temp_i(work_temp_i), .rx_byte_o(rx_byte_o),
      .rx_is_data_o(rx_is_data_o), .rx_valid_o(rx_valid_o), .core_clear_o(core_clear_o));
   ehs_host_model i_ehs_host_model (.ref_clk_i(ref_clk_i), .busy_i(busy_o),
      .sclk_o(sclk), .sdi_o(sdi), .dc_o(dc), .cs_n_o(cs_n));
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic final_report();
      $display("Counts: checked=%0d mismatches=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // Each received unit against the model queue
   always @(negedge ref_clk_i) begin
      if (rx_valid_o === 1'b1) begin
         if (exp_q.size() > 0)
            check({rx_is_data_o, rx_byte_o}, exp_q.pop_front());
         else
            check(9'(rx_valid_o), 9'h000);
      end
   end
   // Hang guard
   always @(negedge ref_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end
   // Main sequence
   initial begin
      seed = 32'hf7bb;
      rst_i = 1'b1;
      module_clear_n_i = 1'b1;
      bus_mode_strap_i = 1'b0;
      work_wave_i = 1'b0;
      work_temp_i = 1'b0;
      repeat (16) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      for (int i = 0; i < 12; i++) begin
         w = 9'($random(seed));
         exp_q.push_back(w);
         i_ehs_host_model.send(w, 8, w[8]);
      end
      i_ehs_host_model.send(9'h0A5, 5, 1'b0);
      i_ehs_host_model.stray(9);
      w = 9'($random(seed));
      exp_q.push_back(w);
      i_ehs_host_model.send(w, 8, w[8]);
      $display("Test four-line done");
      for (int k = 1; k < 3; k++) begin
         {work_temp_i, work_wave_i} = 2'(k);
         repeat (4) @(negedge ref_clk_i);
         check(9'(busy_o), 9'h001);
         {work_temp_i, work_wave_i} = 2'h0;
         repeat (4) @(negedge ref_clk_i);
         check(9'(busy_o), 9'h000);
      end
      w = 9'($random(seed));
      exp_q.push_back(w);
      work_temp_i = 1'b1;
      fork
         i_ehs_host_model.send(w, 8, w[8]);
         begin
            repeat (20) @(negedge ref_clk_i);
            check({busy_o, 7'h00, cs_n}, 9'h101);
            work_temp_i = 1'b0;
         end
      join
      $display("Test busy done");
      module_clear_n_i = 1'b0;
      bus_mode_strap_i = 1'b1;
      work_wave_i = 1'b1;
      repeat (6) @(negedge ref_clk_i);
      check({core_clear_o, 7'h00, busy_o}, 9'h100);
      module_clear_n_i = 1'b1;
      work_wave_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      check(9'(core_clear_o), 9'h000);
      for (int i = 0; i < 12; i++) begin
         w = 9'($random(seed));
         exp_q.push_back(w);
         i_ehs_host_model.send(w, 9, 1'b0);
      end
      repeat (10) @(negedge ref_clk_i);
      check(9'(exp_q.size()), 9'h000);
      $display("Test three-line done");
      final_report();
   end
endmodule : test_epaper_host_serial_ctrl
`default_nettype wire
